// ===== src/wst_pkg.sv
// Constants and carrier types for the watchdog supervision timer
package wst_pkg;
    localparam int unsigned WST_CNT_W     = 16;
    localparam int unsigned WST_PRE_W     = 14;
    localparam int unsigned WST_DIV_SLOW  = 16384;
    localparam int unsigned WST_DIV_FAST  = 256;
    // Default interval: 6.5 ms at a 10 MHz system clock
    localparam int unsigned WST_DEF_US    = 6500;
    localparam int unsigned WST_DEF_KHZ   = 10000;
    localparam int unsigned WST_DEF_CYC   = WST_DEF_US * WST_DEF_KHZ / 1000;
    localparam int unsigned WST_CLK_NS    = 50;
    // Reload 0xFF with the fast ratio gives 256 ticks of 256 cycles
    localparam logic [7:0]  WST_RST_RELOAD = 8'hFF;
    localparam logic        WST_RST_SLOW   = 1'b0;
    localparam logic [15:0] WST_CNT_TOP    = 16'hFFFF;
    localparam logic [7:0]  WST_LOW_RELOAD = 8'h00;

    typedef enum logic [3:0] {
        ST_OFF  = 4'h1,
        ST_RUN  = 4'h2,
        ST_WARN = 4'h4,
        ST_RST  = 4'h8
    } wst_state_t;

    typedef struct packed {
        logic dis;
        logic en;
        logic srv;
    } wst_cmd_t;

    typedef struct packed {
        logic       slow;
        logic [7:0] reload;
    } wst_cfg_t;
endpackage : wst_pkg

// ===== src/wst_watchdog.sv
// Watchdog supervision timer: prescaler, 16-bit up counter, warn then reset
`timescale 1ns/1ns
module wst_watchdog
    import wst_pkg::*;
#(
    parameter int unsigned P_DIV_SLOW = WST_DIV_SLOW,
    parameter int unsigned P_DIV_FAST = WST_DIV_FAST
) (
    input  wire logic            i_clk_sys,
    input  wire logic            i_nrst,
    input  wire wst_cmd_t        i_cmd,
    input  wire logic            i_cfg_wr,
    input  wire wst_cfg_t        i_cfg,
    output logic                 o_running,
    output logic                 o_prewarn_irq,
    output logic                 o_reset_req,
    output logic [WST_CNT_W-1:0] o_count
);
    logic                 rst_meta;
    logic                 rst_n;
    wst_state_t           state;
    wst_state_t           next_state;
    logic [WST_PRE_W-1:0] presc;
    logic [WST_PRE_W-1:0] next_presc;
    logic [WST_CNT_W-1:0] next_count;
    wst_cfg_t             cfg_q;
    wst_cfg_t             next_cfg_q;
    wst_cfg_t             cfg_act;
    wst_cfg_t             next_cfg_act;
    logic                 next_running;
    logic                 next_prewarn;
    logic                 next_reset_req;
    logic [WST_PRE_W-1:0] presc_lim;
    logic                 counting;
    logic                 tick;

    // Reset asserts at once but releases only after two clean edges
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    function automatic logic [WST_CNT_W-1:0] reload_word(input wst_cfg_t c);
        reload_word = {c.reload, WST_LOW_RELOAD};
    endfunction : reload_word

    assign presc_lim = cfg_act.slow ? WST_PRE_W'(P_DIV_SLOW - 1)
                                    : WST_PRE_W'(P_DIV_FAST - 1);
    assign counting  = (state == ST_RUN) || (state == ST_WARN);
    assign tick      = counting && (presc == presc_lim);

    always_comb begin
        next_state     = state;
        next_presc     = presc;
        next_count     = o_count;
        next_cfg_q     = i_cfg_wr ? i_cfg : cfg_q;
        next_cfg_act   = cfg_act;
        next_prewarn   = 1'b0;
        next_reset_req = o_reset_req;
        if (state != ST_RST) begin
            if (i_cmd.srv) begin
                // Service also refreshes a stopped counter
                next_count   = reload_word(cfg_q);
                next_presc   = '0;
                next_cfg_act = cfg_q;
                if (state == ST_WARN) begin
                    next_state = ST_RUN;
                end
            end else if (tick) begin
                next_presc = '0;
                if (o_count == WST_CNT_TOP) begin
                    next_count   = reload_word(cfg_q);
                    next_cfg_act = cfg_q;
                    if (state == ST_RUN) begin
                        next_state   = ST_WARN;
                        next_prewarn = 1'b1;
                    end else begin
                        next_state     = ST_RST;
                        next_reset_req = 1'b1;
                    end
                end else begin
                    next_count = o_count + 16'h0001;
                end
            end else if (counting) begin
                next_presc = presc + 14'h0001;
            end
            // Enable wins when both commands arrive together
            if (i_cmd.en) begin
                if (next_state == ST_OFF) begin
                    next_state = ST_RUN;
                end
            // A disable cannot cancel a reset request raised in this cycle
            end else if (i_cmd.dis && next_state != ST_RST) begin
                next_state = ST_OFF;
            end
        end
        next_running = (next_state != ST_OFF);
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state         <= ST_RUN;
            presc         <= '0;
            o_count       <= {WST_RST_RELOAD, WST_LOW_RELOAD};
            cfg_q         <= '{slow: WST_RST_SLOW, reload: WST_RST_RELOAD};
            cfg_act       <= '{slow: WST_RST_SLOW, reload: WST_RST_RELOAD};
            o_running     <= 1'b1;
            o_prewarn_irq <= 1'b0;
            o_reset_req   <= 1'b0;
        end else begin
            state         <= next_state;
            presc         <= next_presc;
            o_count       <= next_count;
            cfg_q         <= next_cfg_q;
            cfg_act       <= next_cfg_act;
            o_running     <= next_running;
            o_prewarn_irq <= next_prewarn;
            o_reset_req   <= next_reset_req;
        end
    end

    AST_START_RUNNING: assert property (@(posedge i_clk_sys)
        $rose(rst_n) |-> o_running && state == ST_RUN)
        else $error("watchdog not running after reset");

    AST_DISABLE: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n)
        i_cmd.dis && !i_cmd.en && state != ST_RST
        |=> !o_running || o_reset_req)
        else $error("disable command ignored");

    AST_ENABLE: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n)
        i_cmd.en && state != ST_RST |=> o_running ##1 o_running || i_cmd.dis
                                     || $past(i_cmd.dis))
        else $error("enable command ignored");

    AST_WARN_BEFORE_RESET: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n)
        $rose(o_reset_req) |-> $past(state) == ST_WARN && !o_prewarn_irq)
        else $error("reset request without prior prewarning");

    AST_WARN_PULSE: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n)
        o_prewarn_irq |-> (state == ST_WARN
                           || $past(i_cmd.dis) && state == ST_OFF)
                          ##1 !o_prewarn_irq)
        else $error("prewarning not a single pulse");

    AST_HOLD_BETWEEN_TICKS: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n)
        !tick && !i_cmd.srv |=> $stable(o_count))
        else $error("counter moved without a prescaler tick");

    AST_SERVICE_RELOAD: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n)
        i_cmd.srv && state != ST_RST
        |=> o_count == {$past(cfg_q.reload), WST_LOW_RELOAD} && presc == '0)
        else $error("service did not reload counter and prescaler");

    AST_INCREMENT: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n)
        tick && !i_cmd.srv && o_count != WST_CNT_TOP
        |=> o_count == $past(o_count) + 16'h0001)
        else $error("counter did not step by one");

    AST_DEFAULT_INTERVAL: assert property (@(posedge i_clk_sys)
        $rose(rst_n) |-> o_count == 16'hFF00 && !cfg_act.slow)
        else $error("wrong default interval after reset");

    AST_CFG_DEFERRED: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n)
        !i_cmd.srv && !(tick && o_count == WST_CNT_TOP)
        |=> $stable(cfg_act))
        else $error("configuration applied before a reload");

    AST_WARN_SOURCE: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n)
        $rose(o_prewarn_irq) |-> $past(tick) && !$past(i_cmd.srv)
            && $past(o_count) == WST_CNT_TOP && $past(state) == ST_RUN)
        else $error("prewarning without a first overflow");

    AST_RESET_STATE: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n)
        o_reset_req |-> state == ST_RST && o_running)
        else $error("reset request outside the reset request state");

    AST_RESET_HOLDS: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n)
        o_reset_req |=> o_reset_req && $stable(o_count) && $stable(state))
        else $error("reset request state left without a reset");

    AST_STOPPED_FROZEN: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n)
        state == ST_OFF && !i_cmd.srv
        |=> $stable(o_count) && $stable(presc))
        else $error("stopped watchdog kept counting");

    AST_PRESC_RANGE: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n)
        presc <= presc_lim)
        else $error("prescaler beyond its ratio");

    AST_TICK_SPACING: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n)
        tick |=> !tick)
        else $error("two prescaler ticks in a row");

    AST_OVERFLOW_RELOAD: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n)
        tick && !i_cmd.srv && o_count == WST_CNT_TOP
        |=> o_count == {$past(cfg_q.reload), WST_LOW_RELOAD} && presc == '0)
        else $error("overflow did not reload the counter");

    AST_SERVICE_WARN_CLEAR: assert property (@(posedge i_clk_sys)
        disable iff (!rst_n)
        i_cmd.srv && !i_cmd.dis && state == ST_WARN |=> state == ST_RUN)
        else $error("service did not clear the prewarning state");
endmodule : wst_watchdog

// ===== verification/wst_watchdog_tb.sv
// Self-checking bench: cycle model of the watchdog compared every cycle while reset is high
`timescale 1ns/1ns
module wst_watchdog_tb;
    import wst_pkg::*;
    // Short prescaler ratios keep overflow runs brief
    localparam int unsigned DS = 16;
    localparam int unsigned DF = 4;
    logic                 i_clk_sys = 1'b0;
    logic                 i_nrst    = 1'b0;
    wst_cmd_t             i_cmd     = '0;
    logic                 i_cfg_wr  = 1'b0;
    wst_cfg_t             i_cfg     = '0;
    logic                 o_running;
    logic                 o_prewarn_irq;
    logic                 o_reset_req;
    logic [WST_CNT_W-1:0] o_count;
    int                   error_cnt  = 0;
    int                   num_checks = 0;
    logic [31:0]          seed       = 32'h7EA3432E;
    int                   m_sync, m_presc, m_ratio;
    logic [15:0]          m_cnt;
    logic                 m_run, m_warn, m_pw, m_rr;
    wst_cfg_t             m_cfg;
    int                   ps[4] = '{0, 8, 30, 60};
    int                   pe[4] = '{0, 2, 20, 60};

    wst_watchdog #(.P_DIV_SLOW(DS), .P_DIV_FAST(DF)) dut (
        .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_cmd(i_cmd),
        .i_cfg_wr(i_cfg_wr), .i_cfg(i_cfg), .o_running(o_running),
        .o_prewarn_irq(o_prewarn_irq), .o_reset_req(o_reset_req),
        .o_count(o_count));

    always #25 i_clk_sys = ~i_clk_sys;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic reload();
        m_cnt   = {m_cfg.reload, 8'h00};
        m_ratio = m_cfg.slow ? DS : DF;
    endtask : reload

    task automatic step();
        logic go;
        go   = m_run;
        m_pw = 1'b0;
        if (i_cmd.en) m_run = 1'b1;
        else if (i_cmd.dis) m_run = 1'b0;
        if (i_cmd.srv) begin
            reload();
            m_presc = 0;
            m_warn  = 1'b0;
        end else if (go && m_presc == m_ratio - 1) begin
            m_presc = 0;
            if (m_cnt == 16'hFFFF) begin
                reload();
                if (m_warn) m_rr = 1'b1;
                else {m_pw, m_warn} = 2'b11;
            end else m_cnt++;
        end else if (go) m_presc++;
        // Stopping drops a pending prewarning state
        if (i_cmd.dis && !i_cmd.en) m_warn = 1'b0;
        if (i_cfg_wr) m_cfg = i_cfg;
    endtask : step

    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            m_sync = 0;
            m_presc = 0;
            {m_run, m_warn, m_pw, m_rr} = 4'h8;
            m_cfg = '{slow: WST_RST_SLOW, reload: WST_RST_RELOAD};
            reload();
        end else if (m_sync < 2) m_sync++;
        else if (!m_rr) step();
    end

    task automatic chk(input logic [15:0] a, input logic [15:0] b);
        num_checks++;
        if (a !== b) begin
            error_cnt++;
            $display("[ERR] t=%0t got %h exp %h", $time, a, b);
        end
    endtask : chk

    // Skipped while reset is low so a reset edge cannot race the compare
    always @(negedge i_clk_sys) begin
        if (i_nrst) begin
            chk({15'h0, o_running}, {15'h0, m_run | m_rr});
            chk({o_prewarn_irq, o_reset_req}, {m_pw, m_rr});
            chk(o_count, m_cnt);
        end
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    initial begin
        #2000000;
        error_cnt++;
        print_verdict();
    end

    initial begin
        logic [31:0] r;
        for (int t = 0; t < 4; t++) begin
            @(negedge i_clk_sys);
            i_nrst   = 1'b0;
            i_cmd    = '0;
            i_cfg_wr = 1'b0;
            repeat (16) @(negedge i_clk_sys);
            i_nrst = 1'b1;
            repeat (3000) begin
                @(negedge i_clk_sys);
                r = xs();
                i_cmd.srv = (r[7:0] < ps[t]);
                i_cmd.en  = (r[15:8] < pe[t]);
                i_cmd.dis = (r[23:16] < pe[t]);
                i_cfg_wr  = (r[31:28] == 4'h0) && (t > 0);
                r         = xs();
                i_cfg     = wst_cfg_t'(r[8:0]);
            end
            $display("test %0d done, errors %0d", t, error_cnt);
        end
        print_verdict();
    end
endmodule : wst_watchdog_tb
